/* logic/ccs_clock_ctrl.v */
// Clock source decode, PLL control and start-up sequencer of the clock system.
// Functional notes
// - PLL makes a fast clock at eight times its source, the RC oscillator.
// - Low-speed select halves the PLL source, giving a 32 MHz fast clock.
// - Low-speed select cannot be set while the PLL clock is the system clock.
// - PLL runs when its enable bit is set or select is 0001 or 0011.
// - Locked flag in the PLL control/status register shows once PLL locks.
// - RC oscillator and PLL stop in power-down.
// - Compatibility mode runs RC at 6.4 MHz and PLL times four, 25.6 MHz.
// - Compatibility mode offers no low-speed PLL source halving.
// - Compatibility mode divides the system clock by four, giving 1.6 MHz.
// - Select codes map to external, PLL, RC, 128 kHz, low-freq and crystal.
// - A setting bit of one is unprogrammed, zero is programmed.
// - Power-down wake delay counts selected-clock cycles and holds off execution.
// - Reset delay uses watchdog oscillator: 512 cycles 4 ms, 8192 cycles 64 ms.
// - External clock: 6 cycles from power-down; reset 14 cycles plus 0/4/64 ms.
// - Select 0001 divides the PLL output by four for a 16 MHz system clock.
// - PLL clock: wake 14 plus 1K/16K cycles plus 4/64 ms; reset 4 ms.
// - Fast clock or prescaled version may clock Timer/Counter1 or the system.
// - Converter has its own clock domain running while core and I/O halt.
// - Flash interface clock is gated together with the core clock.
// - Fast clock frequency follows changes of the oscillator calibration value.
`timescale 1ns/1ns
`include "ccs_map.vh"
module ccs_clock_ctrl #(
    parameter [15:0] WDT_LONG_CYC = `CCS_WDT_64MS,
    parameter [15:0] WDT_SHORT_CYC = `CCS_WDT_4MS,
    parameter [15:0] CK_LONG_CYC = `CCS_CK_14_16K,
    parameter [15:0] CK_XTAL_CYC = `CCS_CK_16K,
    parameter [15:0] CK_LFX_LONG_CYC = `CCS_CK_32K
) (
    input wire sys_clk,
    input wire reset,
    input wire [3:0] clock_source_select_setting,
    input wire [1:0] startup_time_setting,
    input wire sel_clk_in,
    input wire wdt_osc_in,
    input wire pll_lock_in,
    input wire csr_wr,
    input wire csr_wdata_enable,
    input wire csr_wdata_slow,
    input wire sleep_req,
    input wire [1:0] sleep_mode,
    input wire wake_event,
    input wire [7:0] oscillator_calibration_value,
    input wire tc1_fast_req,
    output reg [7:0] pll_control_status_reg,
    output reg pll_locked_flag,
    output reg pll_on_ff,
    output reg pll_src_div2_ff,
    output reg [3:0] pll_mult_ff,
    output reg rc_osc_on_ff,
    output reg rc_compat_ff,
    output reg sys_div4_ff,
    output reg [2:0] sys_src_ff,
    output reg tc1_fast_sel_ff,
    output reg [16:0] pck_nominal_khz_ff,
    output reg [16:0] sys_nominal_khz_ff,
    output reg [7:0] pll_trim_ff,
    output reg pck_retune_ff,
    output reg core_clk_en_ff,
    output reg io_clk_en_ff,
    output reg flash_interface_clock_en_ff,
    output reg converter_clock_en_ff,
    output reg int_reset_ff,
    output reg exec_hold_ff
);
    localparam [2:0] ST_RST_CK = 3'h0;
    localparam [2:0] ST_RST_WDT = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_SLEEP = 3'h3;
    localparam [2:0] ST_WAKE_CK = 3'h4;
    localparam [2:0] ST_WAKE_WDT = 3'h5;

    reg [3:0] sel_ff;
    reg [1:0] stup_ff;
    reg [2:0] src;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg load_ff;
    reg [1:0] light_mode_ff;
    reg [1:0] nxt_light_mode;
    reg pll_en_ff;
    reg slow_ff;
    reg [15:0] rst_ck;
    reg [15:0] rst_wdt;
    reg [15:0] wake_ck;
    reg [15:0] wake_wdt;
    reg [15:0] cnt_val;
    wire [2:0] async_bus;
    wire [2:0] lvl_bus;
    wire [2:0] rise_bus;
    wire cnt_done;
    wire wdt_phase;
    wire cnt_tick;
    wire pll_is_sys;
    wire compat;
    wire pll_want;
    wire nxt_locked;
    wire nxt_run;

    assign async_bus = {pll_lock_in, wdt_osc_in, sel_clk_in};

    // Selected clock, watchdog oscillator and lock indication cross into sys_clk.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            ccs_sync3 u_sync (
                .sys_clk(sys_clk),
                .reset(reset),
                .async_in(async_bus[gi]),
                .level_ff(lvl_bus[gi]),
                .rise_ff(rise_bus[gi])
            );
        end
    endgenerate

    // Non-volatile settings are captured while reset is held and stay fixed afterwards.
    always @(posedge sys_clk) begin
        if (reset) begin
            sel_ff <= clock_source_select_setting;
            stup_ff <= startup_time_setting;
        end
    end

    // Raw bit values are decoded directly: a one is unprogrammed, a zero programmed.
    always @* begin
        case (sel_ff)
            `CCS_SEL_EXT: src = `CCS_SRC_EXT;
            `CCS_SEL_PLL: src = `CCS_SRC_PLL;
            `CCS_SEL_RC: src = `CCS_SRC_RC;
            `CCS_SEL_COMPAT: src = `CCS_SRC_COMPAT;
            `CCS_SEL_128K: src = `CCS_SRC_128K;
            `CCS_SEL_LFX: src = `CCS_SRC_LFX;
            default: src = sel_ff[3] ? `CCS_SRC_XTAL : `CCS_SRC_RSVD;
        endcase
    end

    assign pll_is_sys = (src == `CCS_SRC_PLL);
    assign compat = (src == `CCS_SRC_COMPAT);

    // Start-up counts per source class and start-up setting.
    always @* begin
        rst_ck = `CCS_CK_14;
        wake_ck = `CCS_CK_6;
        wake_wdt = `CCS_CK_NONE;
        case (stup_ff)
            2'h0: rst_wdt = `CCS_CK_NONE;
            2'h1: rst_wdt = WDT_SHORT_CYC;
            default: rst_wdt = WDT_LONG_CYC;
        endcase
        case (src)
            `CCS_SRC_PLL: begin
                rst_ck = `CCS_CK_NONE;
                rst_wdt = WDT_SHORT_CYC;
                wake_ck = stup_ff[0] ? CK_LONG_CYC : `CCS_CK_14_1K;
                wake_wdt = stup_ff[1] ? WDT_LONG_CYC : WDT_SHORT_CYC;
            end
            `CCS_SRC_COMPAT: begin
                wake_ck = (stup_ff == 2'h3) ? `CCS_CK_1 : `CCS_CK_6;
                case (stup_ff)
                    2'h2: rst_wdt = WDT_SHORT_CYC;
                    2'h3: rst_wdt = `CCS_CK_NONE;
                    default: rst_wdt = WDT_LONG_CYC;
                endcase
            end
            `CCS_SRC_LFX: begin
                rst_ck = `CCS_CK_NONE;
                rst_wdt = (stup_ff == 2'h0) ? WDT_SHORT_CYC : WDT_LONG_CYC;
                wake_ck = stup_ff[1] ? CK_LFX_LONG_CYC : `CCS_CK_1K;
            end
            `CCS_SRC_XTAL: begin
                rst_wdt = WDT_LONG_CYC;
                wake_ck = CK_XTAL_CYC;
            end
            default: begin
                wake_ck = `CCS_CK_6;
            end
        endcase
    end

    // Count value for the phase being entered.
    always @* begin
        case (state_ff)
            ST_RST_CK: cnt_val = rst_ck;
            ST_RST_WDT: cnt_val = rst_wdt;
            ST_WAKE_CK: cnt_val = wake_ck;
            ST_WAKE_WDT: cnt_val = wake_wdt;
            default: cnt_val = `CCS_CK_NONE;
        endcase
    end

    assign wdt_phase = (state_ff == ST_RST_WDT) || (state_ff == ST_WAKE_WDT);
    assign cnt_tick = wdt_phase ? rise_bus[1] : rise_bus[0];

    ccs_delay_cnt u_cnt (
        .sys_clk(sys_clk),
        .reset(reset),
        .load(load_ff),
        .load_val(cnt_val),
        .tick(cnt_tick),
        .done(cnt_done)
    );

    // Sequencer: selected-clock phase, then watchdog phase, then release.
    always @* begin
        nxt_state = state_ff;
        nxt_light_mode = light_mode_ff;
        case (state_ff)
            ST_RST_CK: if (cnt_done) nxt_state = ST_RST_WDT;
            ST_RST_WDT: if (cnt_done) nxt_state = ST_RUN;
            ST_RUN: begin
                if (wake_event) begin
                    nxt_light_mode = 2'h0;
                end else if (sleep_req && sleep_mode == `CCS_MODE_PDOWN) begin
                    nxt_state = ST_SLEEP;
                end else if (sleep_req) begin
                    nxt_light_mode = sleep_mode;
                end
            end
            ST_SLEEP: if (wake_event) nxt_state = ST_WAKE_CK;
            ST_WAKE_CK: if (cnt_done) nxt_state = ST_WAKE_WDT;
            ST_WAKE_WDT: if (cnt_done) nxt_state = ST_RUN;
            default: nxt_state = ST_RST_CK;
        endcase
    end

    // State register; the counter reloads on each phase change.
    always @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= ST_RST_CK;
            load_ff <= 1'b1;
            light_mode_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            load_ff <= (nxt_state != state_ff);
            light_mode_ff <= (nxt_state == ST_RUN) ? nxt_light_mode : 2'h0;
        end
    end

    assign nxt_run = (nxt_state == ST_RUN);

    // Clock gating and hold outputs follow the sequencer and sleep mode.
    always @(posedge sys_clk) begin
        if (reset) begin
            core_clk_en_ff <= 1'b0;
            flash_interface_clock_en_ff <= 1'b0;
            io_clk_en_ff <= 1'b0;
            converter_clock_en_ff <= 1'b0;
            int_reset_ff <= 1'b1;
            exec_hold_ff <= 1'b1;
        end else begin
            core_clk_en_ff <= nxt_run && nxt_light_mode == 2'h0;
            flash_interface_clock_en_ff <= nxt_run && nxt_light_mode == 2'h0;
            io_clk_en_ff <= nxt_run && nxt_light_mode != `CCS_MODE_NOISE;
            converter_clock_en_ff <= nxt_run;
            int_reset_ff <= (nxt_state == ST_RST_CK) || (nxt_state == ST_RST_WDT);
            exec_hold_ff <= !nxt_run;
        end
    end

    // Control bits of the PLL control/status register.
    always @(posedge sys_clk) begin
        if (reset) begin
            pll_en_ff <= `CCS_CSR_EN_RST;
            slow_ff <= `CCS_CSR_SLOW_RST;
        end else if (csr_wr) begin
            pll_en_ff <= csr_wdata_enable;
            slow_ff <= csr_wdata_slow && !pll_is_sys && !compat;
        end
    end

    assign pll_want = pll_en_ff || sel_ff == `CCS_SEL_PLL || sel_ff == `CCS_SEL_COMPAT;
    assign nxt_locked = pll_on_ff && lvl_bus[2];

    // PLL and oscillator control; both stop in power-down.
    always @(posedge sys_clk) begin
        if (reset) begin
            pll_on_ff <= 1'b0;
            rc_osc_on_ff <= 1'b0;
            pll_locked_flag <= 1'b0;
            pll_control_status_reg <= 8'h00;
        end else begin
            pll_on_ff <= pll_want && state_ff != ST_SLEEP;
            rc_osc_on_ff <= state_ff != ST_SLEEP;
            pll_locked_flag <= nxt_locked;
            pll_control_status_reg <= 8'h00;
            pll_control_status_reg[`CCS_CSR_LOCK_BIT] <= nxt_locked;
            pll_control_status_reg[`CCS_CSR_EN_BIT] <= pll_en_ff;
            pll_control_status_reg[`CCS_CSR_SLOW_BIT] <= slow_ff;
        end
    end

    // Multiplier, dividers, source and nominal frequencies.
    always @(posedge sys_clk) begin
        if (reset) begin
            pll_mult_ff <= `CCS_PLL_MULT_NORM;
            pll_src_div2_ff <= 1'b0;
            rc_compat_ff <= 1'b0;
            sys_div4_ff <= 1'b0;
            sys_src_ff <= `CCS_SRC_EXT;
            tc1_fast_sel_ff <= 1'b0;
            pck_nominal_khz_ff <= `CCS_PCK_KHZ_NORM;
            sys_nominal_khz_ff <= 17'h00000;
        end else begin
            pll_mult_ff <= compat ? `CCS_PLL_MULT_COMPAT : `CCS_PLL_MULT_NORM;
            pll_src_div2_ff <= slow_ff;
            rc_compat_ff <= compat;
            sys_div4_ff <= pll_is_sys || compat;
            sys_src_ff <= src;
            tc1_fast_sel_ff <= tc1_fast_req && nxt_locked;
            if (compat) begin
                pck_nominal_khz_ff <= `CCS_PCK_KHZ_COMPAT;
            end else if (slow_ff) begin
                pck_nominal_khz_ff <= `CCS_PCK_KHZ_LOW;
            end else begin
                pck_nominal_khz_ff <= `CCS_PCK_KHZ_NORM;
            end
            if (pll_is_sys) begin
                sys_nominal_khz_ff <= `CCS_SYS_KHZ_PLL;
            end else if (compat) begin
                sys_nominal_khz_ff <= `CCS_SYS_KHZ_COMPAT;
            end else begin
                sys_nominal_khz_ff <= 17'h00000;
            end
        end
    end

    // The PLL trim follows calibration; a change raises a one-cycle retune pulse.
    always @(posedge sys_clk) begin
        if (reset) begin
            pll_trim_ff <= 8'h00;
            pck_retune_ff <= 1'b0;
        end else begin
            pll_trim_ff <= oscillator_calibration_value;
            pck_retune_ff <= oscillator_calibration_value != pll_trim_ff;
        end
    end
endmodule

/* common/ccs_map.vh */
// Constants of the clock source, PLL and start-up controller.
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// Clock source select setting codes; a zero bit is a programmed bit.
`define CCS_SEL_EXT 4'h0
`define CCS_SEL_PLL 4'h1
`define CCS_SEL_RC 4'h2
`define CCS_SEL_COMPAT 4'h3
`define CCS_SEL_128K 4'h4
`define CCS_SEL_LFX 4'h6

// Decoded source classes.
`define CCS_SRC_EXT 3'h0
`define CCS_SRC_PLL 3'h1
`define CCS_SRC_RC 3'h2
`define CCS_SRC_COMPAT 3'h3
`define CCS_SRC_128K 3'h4
`define CCS_SRC_LFX 3'h5
`define CCS_SRC_XTAL 3'h6
`define CCS_SRC_RSVD 3'h7

// Sleep modes.
`define CCS_MODE_IDLE 2'h1
`define CCS_MODE_NOISE 2'h2
`define CCS_MODE_PDOWN 2'h3

// PLL control/status bit positions and reset values.
`define CCS_CSR_LOCK_BIT 0
`define CCS_CSR_EN_BIT 1
`define CCS_CSR_SLOW_BIT 7
`define CCS_CSR_EN_RST 1'h0
`define CCS_CSR_SLOW_RST 1'h0

// PLL factors and nominal frequencies in kHz.
`define CCS_PLL_MULT_NORM 4'h8
`define CCS_PLL_MULT_COMPAT 4'h4
`define CCS_PCK_KHZ_NORM 17'h0fa00
`define CCS_PCK_KHZ_LOW 17'h07d00
`define CCS_PCK_KHZ_COMPAT 17'h06400
`define CCS_SYS_KHZ_PLL 17'h03e80
`define CCS_SYS_KHZ_COMPAT 17'h00640

// Start-up counts: selected-clock cycles and watchdog oscillator cycles.
`define CCS_CK_NONE 16'h0000
`define CCS_CK_1 16'h0001
`define CCS_CK_6 16'h0006
`define CCS_CK_14 16'h000e
`define CCS_CK_1K 16'h0400
`define CCS_CK_14_1K 16'h040e
`define CCS_CK_14_16K 16'h400e
`define CCS_CK_16K 16'h4000
`define CCS_CK_32K 16'h8000
`define CCS_WDT_4MS 16'h0200
`define CCS_WDT_64MS 16'h2000

`endif

/* logic/ccs_sync3.v */
// Three-stage synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ns
module ccs_sync3 (
    input wire sys_clk,
    input wire reset,
    input wire async_in,
    output reg level_ff,
    output reg rise_ff
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;

    // The first stage feeds only the second; a change counts once stages two and three agree.
    always @(posedge sys_clk) begin
        if (reset) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            level_ff <= 1'b0;
            rise_ff <= 1'b0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            rise_ff <= 1'b0;
            if (s2_ff == s3_ff) begin
                level_ff <= s3_ff;
                rise_ff <= s3_ff & ~level_ff;
            end
        end
    end
endmodule

/* logic/ccs_delay_cnt.v */
// Loadable down counter that times start-up phases in selected-clock or watchdog oscillator ticks.
`timescale 1ns/1ns
module ccs_delay_cnt (
    input wire sys_clk,
    input wire reset,
    input wire load,
    input wire [15:0] load_val,
    input wire tick,
    output wire done
);
    reg [15:0] cnt_ff;
    wire [15:0] nxt_cnt;

    // Counts down one per tick and rests at zero.
    assign nxt_cnt = load ? load_val : ((tick && cnt_ff != 16'h0000) ? cnt_ff - 16'h0001 : cnt_ff);
    assign done = (cnt_ff == 16'h0000) && !load;

    // Counter register.
    always @(posedge sys_clk) begin
        if (reset) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

/* verification/ccs_clock_ctrl_props.sv */
// Concurrent checks on the ports of the clock source and start-up controller.
`timescale 1ns/1ns
`include "ccs_map.vh"
module ccs_clock_ctrl_props (
    input wire sys_clk,
    input wire reset,
    input wire [1:0] sleep_mode,
    input wire sleep_req,
    input wire wake_event,
    input wire [7:0] oscillator_calibration_value,
    input wire pll_locked_flag,
    input wire pll_on_ff,
    input wire pll_src_div2_ff,
    input wire [3:0] pll_mult_ff,
    input wire rc_osc_on_ff,
    input wire sys_div4_ff,
    input wire [2:0] sys_src_ff,
    input wire [7:0] pll_trim_ff,
    input wire pck_retune_ff,
    input wire core_clk_en_ff,
    input wire flash_interface_clock_en_ff,
    input wire converter_clock_en_ff,
    input wire int_reset_ff,
    input wire exec_hold_ff
);
    // All checks run on the system clock and rest while reset is high.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // A power-down request taken in the run state, then both oscillators off.
    sequence s_pd_req;
        sleep_req && sleep_mode == `CCS_MODE_PDOWN && !exec_hold_ff && !wake_event;
    endsequence
    sequence s_osc_off;
        !rc_osc_on_ff && !pll_on_ff;
    endsequence

    AST_PD_OFF: assert property (s_pd_req |-> ##[1:3] s_osc_off)
        else $error("oscillators still running in power-down");
    AST_PLL_EN: assert property (!exec_hold_ff && (sys_src_ff == `CCS_SRC_PLL ||
        sys_src_ff == `CCS_SRC_COMPAT) |-> pll_on_ff)
        else $error("pll off while selected by the setting");
    AST_LOCK: assert property (pll_locked_flag |-> $past(pll_on_ff))
        else $error("locked flag without a running pll");
    AST_SLOW_OFF: assert property ((sys_src_ff == `CCS_SRC_PLL ||
        sys_src_ff == `CCS_SRC_COMPAT) |-> !pll_src_div2_ff)
        else $error("pll source halved while not allowed");
    AST_DIV4: assert property (sys_div4_ff == (sys_src_ff == `CCS_SRC_PLL ||
        sys_src_ff == `CCS_SRC_COMPAT))
        else $error("system divide by four wrong for the source");
    AST_MULT: assert property (pll_mult_ff ==
        ((sys_src_ff == `CCS_SRC_COMPAT) ? 4'h4 : 4'h8))
        else $error("pll factor wrong for the source");
    AST_RETUNE: assert property (oscillator_calibration_value != pll_trim_ff
        |-> ##[1:2] pck_retune_ff)
        else $error("no retune after calibration change");
    AST_FLASH: assert property (flash_interface_clock_en_ff == core_clk_en_ff)
        else $error("flash gate differs from core gate");
    AST_CONV: assert property (core_clk_en_ff |-> converter_clock_en_ff)
        else $error("converter gated while core runs");
    AST_RUN_ENTRY: assert property ($fell(exec_hold_ff) |->
        core_clk_en_ff && converter_clock_en_ff && !int_reset_ff)
        else $error("run entered without gates released");
endmodule

bind ccs_clock_ctrl ccs_clock_ctrl_props u_props (
    .sys_clk(sys_clk), .reset(reset), .sleep_mode(sleep_mode), .sleep_req(sleep_req),
    .wake_event(wake_event), .oscillator_calibration_value(oscillator_calibration_value),
    .pll_locked_flag(pll_locked_flag), .pll_on_ff(pll_on_ff),
    .pll_src_div2_ff(pll_src_div2_ff), .pll_mult_ff(pll_mult_ff),
    .rc_osc_on_ff(rc_osc_on_ff), .sys_div4_ff(sys_div4_ff), .sys_src_ff(sys_src_ff),
    .pll_trim_ff(pll_trim_ff), .pck_retune_ff(pck_retune_ff),
    .core_clk_en_ff(core_clk_en_ff), .flash_interface_clock_en_ff(flash_interface_clock_en_ff),
    .converter_clock_en_ff(converter_clock_en_ff), .int_reset_ff(int_reset_ff),
    .exec_hold_ff(exec_hold_ff)
);

/* verification/ccs_osc_model.sv */
// Stand-ins for the selected clock source, watchdog oscillator and PLL lock.
`timescale 1ns/1ns
module ccs_osc_model (
    input wire sys_clk,
    input wire pll_on_ff,
    output reg sel_clk_in,
    output reg wdt_osc_in,
    output reg pll_lock_in
);
    integer lock_cnt;

    // Steady sources of eight system clocks a period, in unrelated phase.
    initial begin
        sel_clk_in = 1'b0;
        wdt_osc_in = 1'b0;
        pll_lock_in = 1'b0;
        lock_cnt = 0;
        fork
            forever #200 sel_clk_in = ~sel_clk_in;
            begin
                #75;
                forever #200 wdt_osc_in = ~wdt_osc_in;
            end
        join
    end

    // Lock follows twenty-one cycles after the PLL starts and drops when it stops.
    always @(posedge sys_clk) begin
        if (!pll_on_ff) begin
            lock_cnt <= 0;
            pll_lock_in <= 1'b0;
        end else if (lock_cnt < 20) begin
            lock_cnt <= lock_cnt + 1;
        end else begin
            pll_lock_in <= 1'b1;
        end
    end
endmodule

/* verification/test_clock_source_pll_startup.sv */
// Self-checking bench for the clock source, PLL and start-up controller.
`timescale 1ns/1ns
`include "ccs_map.vh"
module test_clock_source_pll_startup;
    localparam integer P = 8;
    reg sys_clk, reset, csr_wr, csr_en, csr_slow, sleep_req, wake_event, tc1_req;
    reg [3:0] sel;
    reg [1:0] stup;
    reg [1:0] mode;
    reg [7:0] cal;
    wire sel_clk_in, wdt_osc_in, pll_lock_in, lock, pll_on, div2, rc_on, compat, div4;
    wire tc1_sel, retune, core, io, flash, conv, ires, hold;
    wire [7:0] csr, trim;
    wire [3:0] mult;
    wire [2:0] src;
    wire [16:0] pck, sysk;
    integer err_count, checked;

    // Start-up counts shortened so that each boot takes at most 30 source ticks, 240 cycles.
    ccs_clock_ctrl #(.WDT_LONG_CYC(16'h0010), .WDT_SHORT_CYC(16'h0008),
        .CK_LONG_CYC(16'h0014), .CK_XTAL_CYC(16'h000a), .CK_LFX_LONG_CYC(16'h000c)) uut (
        .sys_clk(sys_clk), .reset(reset), .clock_source_select_setting(sel),
        .startup_time_setting(stup), .sel_clk_in(sel_clk_in), .wdt_osc_in(wdt_osc_in),
        .pll_lock_in(pll_lock_in), .csr_wr(csr_wr), .csr_wdata_enable(csr_en),
        .csr_wdata_slow(csr_slow), .sleep_req(sleep_req), .sleep_mode(mode),
        .wake_event(wake_event), .oscillator_calibration_value(cal), .tc1_fast_req(tc1_req),
        .pll_control_status_reg(csr), .pll_locked_flag(lock), .pll_on_ff(pll_on),
        .pll_src_div2_ff(div2), .pll_mult_ff(mult), .rc_osc_on_ff(rc_on),
        .rc_compat_ff(compat), .sys_div4_ff(div4), .sys_src_ff(src), .tc1_fast_sel_ff(tc1_sel),
        .pck_nominal_khz_ff(pck), .sys_nominal_khz_ff(sysk), .pll_trim_ff(trim),
        .pck_retune_ff(retune), .core_clk_en_ff(core), .io_clk_en_ff(io),
        .flash_interface_clock_en_ff(flash), .converter_clock_en_ff(conv),
        .int_reset_ff(ires), .exec_hold_ff(hold));

    ccs_osc_model osc (.sys_clk(sys_clk), .pll_on_ff(pll_on), .sel_clk_in(sel_clk_in),
        .wdt_osc_in(wdt_osc_in), .pll_lock_in(pll_lock_in));

    // Free-running 20 MHz system clock.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task check(input string name, input [16:0] seen, input [16:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("Error %0s expected %0h seen %0h", name, exp, seen);
            end
        end
    endtask

    task results;
        begin
            $display("checks %0d mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    task wait_run(output integer n);
        begin
            n = 0;
            while (hold !== 1'b0 && n < 20000) begin
                @(negedge sys_clk);
                n = n + 1;
            end
        end
    endtask

    // Boots with one setting and checks the delay in source ticks and the decode.
    task b(input [3:0] s, input [1:0] t, input [2:0] c, input integer k);
        integer n;
        begin
            @(negedge sys_clk);
            reset = 1'b1;
            sel = s;
            stup = t;
            repeat (5) @(negedge sys_clk);
            reset = 1'b0;
            wait_run(n);
            check("start", n >= (k - 1) * P && n <= (k + 1) * P + 16, 1'b1);
            check("src", src, c);
            check("pll_on", {ires, pll_on}, s == 4'h1 || s == 4'h3);
            check("div4", div4, s == 4'h1 || s == 4'h3);
        end
    endtask

    task csr_write(input e, input l);
        begin
            @(negedge sys_clk);
            csr_wr = 1'b1;
            csr_en = e;
            csr_slow = l;
            @(negedge sys_clk);
            csr_wr = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
    endtask

    // Each decoded code except PLL and RC with its own reset delay; codes are raw, zero programmed.
    task t_boots;
        begin
            b(4'h0, 2'b00, `CCS_SRC_EXT, 14);
            b(4'h0, 2'b01, `CCS_SRC_EXT, 22);
            b(4'h0, 2'b10, `CCS_SRC_EXT, 30);
            b(4'h3, 2'b00, `CCS_SRC_COMPAT, 30);
            b(4'h3, 2'b10, `CCS_SRC_COMPAT, 22);
            b(4'h4, 2'b01, `CCS_SRC_128K, 22);
            b(4'h6, 2'b00, `CCS_SRC_LFX, 8);
            b(4'h6, 2'b01, `CCS_SRC_LFX, 16);
            b(4'h8, 2'b00, `CCS_SRC_XTAL, 30);
            b(4'hf, 2'b00, `CCS_SRC_XTAL, 30);
            b(4'h5, 2'b00, `CCS_SRC_RSVD, 14);
        end
    endtask

    // Enable and low-speed bits on the RC clock, then lock and the timer clock.
    task t_csr;
        integer n;
        begin
            b(4'h2, 2'b00, `CCS_SRC_RC, 14);
            csr_write(1'b1, 1'b1);
            check("csr", csr & 8'h82, 8'h82);
            check("pck", pck, `CCS_PCK_KHZ_LOW);
            for (n = 0; n < 60 && lock !== 1'b1; n = n + 1) @(negedge sys_clk);
            check("lock", {lock, csr[0]}, 2'b11);
            tc1_req = 1'b1;
            repeat (3) @(negedge sys_clk);
            check("tc1", tc1_sel, 1'b1);
            tc1_req = 1'b0;
            csr_write(1'b0, 1'b0);
            check("pll_on", pll_on, 1'b0);
            check("pck", pck, `CCS_PCK_KHZ_NORM);
        end
    endtask

    // Low-speed writes refused with the PLL or compatibility clock selected.
    task t_refuse;
        begin
            b(4'h1, 2'b00, `CCS_SRC_PLL, 8);
            csr_write(1'b1, 1'b1);
            check("slow", csr[7], 1'b0);
            check("sysk", sysk, `CCS_SYS_KHZ_PLL);
            b(4'h3, 2'b11, `CCS_SRC_COMPAT, 14);
            csr_write(1'b1, 1'b1);
            check("slow", div2, 1'b0);
            check("mult", {compat, mult}, {1'b1, `CCS_PLL_MULT_COMPAT});
            check("pck", pck, `CCS_PCK_KHZ_COMPAT);
            check("sysk", sysk, `CCS_SYS_KHZ_COMPAT);
        end
    endtask

    // A calibration step, kept low enough for the PLL to stay locked.
    task t_cal;
        reg r;
        begin
            r = 1'b0;
            @(negedge sys_clk);
            cal = 8'h5a;
            repeat (3) begin
                @(negedge sys_clk);
                r = r | retune;
            end
            check("trim", {r, trim}, {1'b1, 8'h5a});
            cal = 8'h00;
            repeat (3) @(negedge sys_clk);
        end
    endtask

    // Idle or noise sleep: core and flash halt, converter keeps running.
    task light(input [1:0] m, input i);
        begin
            @(negedge sys_clk);
            sleep_req = 1'b1;
            mode = m;
            @(negedge sys_clk);
            sleep_req = 1'b0;
            repeat (2) @(negedge sys_clk);
            check("gates", {core, flash, io, conv}, {2'b00, i, 1'b1});
            wake_event = 1'b1;
            @(negedge sys_clk);
            wake_event = 1'b0;
            repeat (3) @(negedge sys_clk);
            check("core", {core, flash}, 2'b11);
        end
    endtask

    // Power-down stops the oscillators; wake waits k source ticks.
    task pd(input integer k);
        integer n;
        begin
            @(negedge sys_clk);
            sleep_req = 1'b1;
            mode = `CCS_MODE_PDOWN;
            @(negedge sys_clk);
            sleep_req = 1'b0;
            repeat (3) @(negedge sys_clk);
            check("osc", {rc_on, pll_on, conv, hold}, 4'b0001);
            wake_event = 1'b1;
            @(negedge sys_clk);
            wake_event = 1'b0;
            wait_run(n);
            check("wake", n >= (k - 1) * P && n <= (k + 1) * P + 16, 1'b1);
        end
    endtask

    // Main sequence.
    initial begin
        reset = 1'b1;
        sel = 4'h0;
        stup = 2'b00;
        mode = 2'h0;
        cal = 8'h00;
        {csr_wr, csr_en, csr_slow, sleep_req, wake_event, tc1_req} = 6'h00;
        err_count = 0;
        checked = 0;
        t_boots;
        t_csr;
        t_refuse;
        t_cal;
        b(4'h0, 2'b00, `CCS_SRC_EXT, 14);
        light(`CCS_MODE_IDLE, 1'b1);
        light(`CCS_MODE_NOISE, 1'b0);
        pd(6);
        b(4'h1, 2'b01, `CCS_SRC_PLL, 8);
        pd(28);
        results;
    end

    // Watchdog: the run needs under 10000 cycles, so 20000 means a hang.
    initial begin
        #1000000;
        err_count = err_count + 1;
        results;
    end
endmodule
